//--- rtl/pomc_map.vh
// Constants for the operating mode controller
`ifndef POMC_MAP_VH
`define POMC_MAP_VH
// ************************************************************
// Operating modes
// ************************************************************
`define POMC_MODE_STOP 2'h0
`define POMC_MODE_START 2'h1
`define POMC_MODE_RUN 2'h2
`define POMC_MODE_HOLD 2'h3
// ************************************************************
// Cycle phases
// ************************************************************
`define POMC_PH_IDLE 3'h0
`define POMC_PH_CLR_IN 3'h1
`define POMC_PH_RESTART 3'h2
`define POMC_PH_CLR_OUT 3'h3
`define POMC_PH_READ_IN 3'h4
`define POMC_PH_MAIN 3'h5
`define POMC_PH_WRITE_OUT 3'h6
// ************************************************************
// Timing, clock 200 MHz
// ************************************************************
`define POMC_CLK_HZ 200000000
`define POMC_WDOG_MS 100
`define POMC_CYC_MIN_MS 1
`define POMC_START_BLINK_S 3
`define POMC_HOLD_BLINK_HZ 1
`define POMC_WDOG_CYC (`POMC_CLK_HZ / 1000 * `POMC_WDOG_MS)
`define POMC_MS_CYC (`POMC_CLK_HZ / 1000 * `POMC_CYC_MIN_MS)
`define POMC_START_CYC (`POMC_CLK_HZ * `POMC_START_BLINK_S)
`define POMC_HALF_HZ_CYC (`POMC_CLK_HZ / (2 * `POMC_HOLD_BLINK_HZ))
// ************************************************************
// Analog output codes while locked
// ************************************************************
`define POMC_AO_KIND_V 2'h0
`define POMC_AO_KIND_020 2'h1
`define POMC_AO_KIND_420 2'h2
`define POMC_AO_ZERO 16'h0000
`define POMC_AO_4MA 16'h3333
// ************************************************************
// Breakpoints
// ************************************************************
`define POMC_BP_NUM 3
`define POMC_BP_STEP_MAX 2
`endif

//--- rtl/pomc_timer.v
// Down counter that flags expiry, used for supervision and blink timing
`timescale 1ns/1ps
module pomc_timer #(
	parameter W = 32
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Control
	input wire restart,
	input wire run,
	input wire [W-1:0] load_val,
	// Status
	output reg expired_q
);
	reg [W-1:0] cnt_q;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= {W{1'b0}};
			expired_q <= 1'b0;
		end else if (restart) begin
			cnt_q <= load_val;
			expired_q <= 1'b0;
		end else if (run) begin
			if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
				expired_q <= 1'b1;
			end else begin
				cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule

//--- rtl/pomc_ao_lock.v
// Analog output value selection with substitute values while outputs are locked
`timescale 1ns/1ps
`include "pomc_map.vh"
module pomc_ao_lock #(
	parameter N = 4
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Control
	input wire output_lock,
	input wire [N-1:0] subst_en,
	input wire [2*N-1:0] ao_kind,
	// Values
	input wire [16*N-1:0] ao_prog,
	input wire [16*N-1:0] ao_subst,
	output reg [16*N-1:0] ao_out_q
);
	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_ch
			wire [15:0] lock_val;
			assign lock_val = (ao_kind[2*i+1:2*i] == `POMC_AO_KIND_420) ? `POMC_AO_4MA : `POMC_AO_ZERO;
			always @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					ao_out_q[16*i+15:16*i] <= `POMC_AO_ZERO;
				end else if (!output_lock) begin
					ao_out_q[16*i+15:16*i] <= ao_prog[16*i+15:16*i];
				end else if (subst_en[i]) begin
					ao_out_q[16*i+15:16*i] <= ao_subst[16*i+15:16*i];
				end else begin
					ao_out_q[16*i+15:16*i] <= lock_val;
				end
			end
		end
	endgenerate
endmodule

//--- rtl/pomc_ctrl.v
// Operating mode controller: STOP, START-UP, RUN and HOLD sequencing
// What this block does
// - After watchdog error, restart only via cold start, overall reset or project reload
// - Green lamp steady in RUN once the start-up blink has ended
// - Output lock released in RUN
// - RUN cycles read inputs, main, write outputs
// - Timers active, image refreshed each cycle
// - Up to three breakpoints held
// - Reaching active breakpoint enters HOLD
// - HOLD: red steady, green blinks 1 Hz
// - HOLD freezes execution and timers, clock runs
// - HOLD asserts output lock, links stay up
// - No stepping with more than two breakpoints
// - Fixed 100 ms watchdog forces STOP
// - Cycle time limit, at least 1 ms
// - RUN to STOP sets output lock
// - Locked analog outputs show safe values
// - Start-up order: clear inputs, restart, release
// - Overall reset in STOP erases user memory, not card
// - STOP runs nothing, keeps data, locks outputs
// - Yellow lamp lit in STOP
// - Start-up green blink lasts at least 3 s
`timescale 1ns/1ps
`include "pomc_map.vh"
module pomc_ctrl #(
	parameter WDOG_CYC = `POMC_WDOG_CYC,
	parameter START_CYC = `POMC_START_CYC,
	parameter HALF_HZ_CYC = `POMC_HALF_HZ_CYC,
	parameter MS_CYC = `POMC_MS_CYC,
	parameter AO_N = 4,
	parameter PC_W = 16
) (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Mode requests from switch and programming side
	input wire run_req,
	input wire stop_req,
	input wire cold_start_present,
	input wire overall_reset_req,
	input wire project_reload,
	// Breakpoints from programming side
	input wire [`POMC_BP_NUM-1:0] bp_active,
	input wire [PC_W*`POMC_BP_NUM-1:0] bp_addr,
	input wire step_req,
	input wire resume_req,
	// Program engine handshake
	input wire [PC_W-1:0] exec_addr,
	input wire phase_done,
	input wire wdog_kick,
	input wire [15:0] cycle_limit_ms,
	// Analog outputs
	input wire [AO_N-1:0] subst_en,
	input wire [2*AO_N-1:0] ao_kind,
	input wire [16*AO_N-1:0] ao_prog,
	input wire [16*AO_N-1:0] ao_subst,
	output wire [16*AO_N-1:0] ao_out,
	// Mode and phase
	output reg [1:0] mode_q,
	output reg [2:0] phase_q,
	output wire exec_en,
	output wire timers_run,
	output wire step_allowed,
	// Output lock and memory
	output reg output_lock_q,
	output reg user_mem_clear_q,
	output reg wdog_err_q,
	output reg cycle_err_q,
	// Status lamps
	output reg led_green_q,
	output reg led_yellow_q,
	output reg led_red_q
);
	// ************************************************************
	// Breakpoint match
	// ************************************************************
	wire [`POMC_BP_NUM-1:0] bp_hit;
	genvar i;
	generate
		for (i = 0; i < `POMC_BP_NUM; i = i + 1) begin : g_bp
			assign bp_hit[i] = bp_active[i] && (bp_addr[PC_W*i+PC_W-1:PC_W*i] == exec_addr);
		end
	endgenerate
	// Stepping is refused once all three entries are armed
	wire [1:0] bp_count;
	assign bp_count = {1'b0, bp_active[0]} + {1'b0, bp_active[1]} + {1'b0, bp_active[2]};
	assign step_allowed = (bp_count <= `POMC_BP_STEP_MAX);

	// ************************************************************
	// Supervision timers
	// ************************************************************
	wire wdog_exp;
	wire cyc_exp;
	wire blink_exp;
	wire start_exp;
	wire cycle_start;
	reg step_q;
	reg blink_q;
	reg start_blink_q;
	assign cycle_start = (mode_q == `POMC_MODE_RUN) && (phase_q == `POMC_PH_CLR_OUT || phase_q == `POMC_PH_WRITE_OUT)
		&& phase_done;
	// Watchdog and cycle limit reload whenever not in RUN, so a debug session in HOLD never trips them
	wire sup_run;
	assign sup_run = (mode_q == `POMC_MODE_RUN);
	wire [15:0] lim_ms;
	assign lim_ms = (cycle_limit_ms == 16'h0000) ? 16'h0001 : cycle_limit_ms;

	// Product formed at full width so long limits never wrap
	wire [31:0] ms_cyc_w;
	assign ms_cyc_w = MS_CYC;
	wire [47:0] cyc_load;
	assign cyc_load = {32'h0000_0000, lim_ms} * {16'h0000, ms_cyc_w};

	pomc_timer #(.W(32)) u_wdog (
		.ref_clk(ref_clk),
		.rst(rst),
		.restart(wdog_kick || !sup_run),
		.run(sup_run),
		.load_val(WDOG_CYC),
		.expired_q(wdog_exp)
	);

	// Cycle span is read, main and write; start-up stays untimed
	pomc_timer #(.W(48)) u_cyc (
		.ref_clk(ref_clk),
		.rst(rst),
		.restart(cycle_start || !sup_run),
		.run(sup_run),
		.load_val(cyc_load),
		.expired_q(cyc_exp)
	);

	// Load one short so each half period is exactly HALF_HZ_CYC edges
	wire [31:0] blink_load;
	assign blink_load = HALF_HZ_CYC - 32'h0000_0001;

	pomc_timer #(.W(32)) u_blink (
		.ref_clk(ref_clk),
		.rst(rst),
		.restart(blink_exp),
		.run(1'b1),
		.load_val(blink_load),
		.expired_q(blink_exp)
	);

	pomc_timer #(.W(32)) u_start (
		.ref_clk(ref_clk),
		.rst(rst),
		.restart(mode_q == `POMC_MODE_START && !start_blink_q),
		.run(start_blink_q),
		.load_val(START_CYC),
		.expired_q(start_exp)
	);

	// ************************************************************
	// Mode and phase sequencing
	// ************************************************************
	reg [1:0] mode_d;
	reg [2:0] phase_d;
	wire fault;
	assign fault = (wdog_exp || cyc_exp) && (mode_q == `POMC_MODE_RUN);
	always @* begin
		mode_d = mode_q;
		phase_d = phase_q;
		case (mode_q)
			`POMC_MODE_STOP: begin
				phase_d = `POMC_PH_IDLE;
				// A watchdog fault blocks plain restart until cleared
				if (run_req && !stop_req && (!wdog_err_q || cold_start_present)) begin
					mode_d = `POMC_MODE_START;
					phase_d = `POMC_PH_CLR_IN;
				end
			end
			`POMC_MODE_START: begin
				if (stop_req) begin
					mode_d = `POMC_MODE_STOP;
					phase_d = `POMC_PH_IDLE;
				end else if (phase_done) begin
					case (phase_q)
						`POMC_PH_CLR_IN: phase_d = `POMC_PH_RESTART;
						`POMC_PH_RESTART: begin
							mode_d = `POMC_MODE_RUN;
							phase_d = `POMC_PH_CLR_OUT;
						end
						default: phase_d = `POMC_PH_CLR_IN;
					endcase
				end
			end
			`POMC_MODE_RUN: begin
				if (fault || stop_req) begin
					mode_d = `POMC_MODE_STOP;
					phase_d = `POMC_PH_IDLE;
				end else if (phase_q == `POMC_PH_MAIN && |bp_hit) begin
					mode_d = `POMC_MODE_HOLD;
				end else if (phase_done) begin
					case (phase_q)
						`POMC_PH_CLR_OUT: phase_d = `POMC_PH_READ_IN;
						`POMC_PH_READ_IN: phase_d = `POMC_PH_MAIN;
						`POMC_PH_MAIN: phase_d = `POMC_PH_WRITE_OUT;
						`POMC_PH_WRITE_OUT: phase_d = `POMC_PH_READ_IN;
						default: phase_d = `POMC_PH_READ_IN;
					endcase
				end
			end
			`POMC_MODE_HOLD: begin
				if (stop_req) begin
					mode_d = `POMC_MODE_STOP;
					phase_d = `POMC_PH_IDLE;
				end else if (resume_req) begin
					mode_d = `POMC_MODE_RUN;
				end
			end
			default: begin
				mode_d = `POMC_MODE_STOP;
				phase_d = `POMC_PH_IDLE;
			end
		endcase
	end

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_q <= `POMC_MODE_STOP;
			phase_q <= `POMC_PH_IDLE;
			wdog_err_q <= 1'b0;
			cycle_err_q <= 1'b0;
			user_mem_clear_q <= 1'b0;
			step_q <= 1'b0;
			blink_q <= 1'b0;
			start_blink_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			phase_q <= phase_d;
			// Fault flags set win over any clear in the same cycle
			if (mode_q == `POMC_MODE_RUN && wdog_exp) begin
				wdog_err_q <= 1'b1;
			end else if (overall_reset_req || project_reload ||
				(mode_q == `POMC_MODE_START && phase_q == `POMC_PH_RESTART && phase_done)) begin
				wdog_err_q <= 1'b0;
			end
			if (mode_q == `POMC_MODE_RUN && cyc_exp) begin
				cycle_err_q <= 1'b1;
			end else if (mode_d == `POMC_MODE_START) begin
				cycle_err_q <= 1'b0;
			end
			// Erase happens only in STOP; card contents are outside this block
			user_mem_clear_q <= overall_reset_req && (mode_q == `POMC_MODE_STOP);
			step_q <= (mode_q == `POMC_MODE_HOLD) && step_req && step_allowed && !resume_req;
			if (blink_exp) begin
				blink_q <= ~blink_q;
			end
			// Blink holds for its full span even if start-up ends early
			if (mode_q == `POMC_MODE_START && !start_blink_q) begin
				start_blink_q <= 1'b1;
			end else if (start_exp) begin
				start_blink_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Execution enables
	// ************************************************************
	// One statement runs for a step pulse in HOLD
	assign exec_en = (mode_q == `POMC_MODE_RUN) || (mode_q == `POMC_MODE_START) || step_q;
	assign timers_run = (mode_q == `POMC_MODE_RUN);

	// ************************************************************
	// Output lock and lamps
	// ************************************************************
	// Driven from the next mode so lamps and lock move with mode_q
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			output_lock_q <= 1'b1;
			led_green_q <= 1'b0;
			led_yellow_q <= 1'b0;
			led_red_q <= 1'b0;
		end else begin
			output_lock_q <= (mode_d != `POMC_MODE_RUN);
			led_yellow_q <= (mode_d == `POMC_MODE_STOP);
			led_red_q <= (mode_d == `POMC_MODE_HOLD);
			if (start_blink_q) begin
				led_green_q <= blink_q;
			end else if (mode_d == `POMC_MODE_HOLD) begin
				led_green_q <= blink_q;
			end else begin
				led_green_q <= (mode_d == `POMC_MODE_RUN);
			end
		end
	end

	pomc_ao_lock #(.N(AO_N)) u_ao (
		.ref_clk(ref_clk),
		.rst(rst),
		.output_lock(output_lock_q),
		.subst_en(subst_en),
		.ao_kind(ao_kind),
		.ao_prog(ao_prog),
		.ao_subst(ao_subst),
		.ao_out_q(ao_out)
	);
endmodule

//--- bench/pomc_engine_model.sv
// Program engine and field image model answering the controller phases
`timescale 1ns/1ps
`include "pomc_map.vh"
module pomc_engine_model (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Controller state
	input wire [1:0] mode_q,
	input wire [2:0] phase_q,
	input wire kick_en,
	input wire [15:0] lat,
	// Engine answers
	output reg phase_done,
	output reg wdog_kick,
	output reg [15:0] exec_addr
);
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			phase_done <= 1'b0;
			wdog_kick <= 1'b0;
			exec_addr <= 16'h0000;
		end else begin
			phase_done <= 1'b0;
			// Kick once per cycle, so a long lat or kick_en low is what starves the watchdog
			wdog_kick <= kick_en && phase_done && phase_q == `POMC_PH_WRITE_OUT;
			if (mode_q == `POMC_MODE_STOP)
				exec_addr <= 16'h0000;
			else if (mode_q != `POMC_MODE_HOLD && !phase_done) begin
				exec_addr <= exec_addr + 16'h0001;
				if (exec_addr == lat) begin
					phase_done <= 1'b1;
					exec_addr <= 16'h0000;
				end
			end
		end
	end
endmodule

//--- bench/pomc_ctrl_props.sv
// Concurrent checks on the mode controller ports
`timescale 1ns/1ps
`include "pomc_map.vh"
module pomc_ctrl_props (
	// Clock and reset
	input wire ref_clk,
	input wire rst,
	// Requests
	input wire run_req,
	input wire stop_req,
	input wire cold_start_present,
	input wire overall_reset_req,
	input wire project_reload,
	input wire [2:0] bp_active,
	input wire [47:0] bp_addr,
	input wire [15:0] exec_addr,
	input wire [3:0] subst_en,
	input wire [7:0] ao_kind,
	// Results
	input wire [63:0] ao_out,
	input wire [1:0] mode_q,
	input wire [2:0] phase_q,
	input wire timers_run,
	input wire step_allowed,
	input wire output_lock_q,
	input wire wdog_err_q,
	input wire led_yellow_q,
	input wire led_red_q
);
	localparam [1:0] STP = `POMC_MODE_STOP;
	localparam [1:0] RN = `POMC_MODE_RUN;
	localparam [1:0] HD = `POMC_MODE_HOLD;
	wire hit = bp_active[0] && bp_addr[15:0] == exec_addr || bp_active[1] && bp_addr[31:16] == exec_addr
		|| bp_active[2] && bp_addr[47:32] == exec_addr;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_run_unlock: assert property (mode_q == RN |-> !output_lock_q)
		else $error("lock set in run");
	a_lock_else: assert property (mode_q != RN |-> output_lock_q)
		else $error("lock clear outside run");
	a_timer_mode: assert property (timers_run == (mode_q == RN))
		else $error("timers wrong");
	a_step_limit: assert property (step_allowed == ($countones(bp_active) <= 2))
		else $error("step permit wrong");
	a_stop_yellow: assert property (mode_q == STP ##1 mode_q == STP |-> led_yellow_q)
		else $error("yellow off in stop");
	a_hold_red: assert property (mode_q == HD |-> led_red_q)
		else $error("red off in hold");
	a_bp_hold: assert property (mode_q == RN && phase_q == `POMC_PH_MAIN && hit && !stop_req |=> mode_q == HD)
		else $error("breakpoint missed");
	a_run_refuse: assert property (mode_q == STP && wdog_err_q && !cold_start_present && !overall_reset_req
		&& !project_reload |=> mode_q == STP)
		else $error("left stop after watchdog");
	a_start_entry: assert property (mode_q == STP && run_req && !stop_req && !wdog_err_q
		|=> mode_q == `POMC_MODE_START && phase_q == `POMC_PH_CLR_IN)
		else $error("start-up entry wrong");
	a_ao_safe: assert property ((output_lock_q && !subst_en[0] && ao_kind[1:0] == `POMC_AO_KIND_420) [*2]
		|=> ao_out[15:0] == `POMC_AO_4MA)
		else $error("locked 4mA wrong");
endmodule
bind pomc_ctrl pomc_ctrl_props u_props (.ref_clk(ref_clk), .rst(rst), .run_req(run_req), .stop_req(stop_req),
	.cold_start_present(cold_start_present), .overall_reset_req(overall_reset_req),
	.project_reload(project_reload), .bp_active(bp_active), .bp_addr(bp_addr), .exec_addr(exec_addr),
	.subst_en(subst_en), .ao_kind(ao_kind), .ao_out(ao_out), .mode_q(mode_q), .phase_q(phase_q),
	.timers_run(timers_run), .step_allowed(step_allowed), .output_lock_q(output_lock_q),
	.wdog_err_q(wdog_err_q), .led_yellow_q(led_yellow_q), .led_red_q(led_red_q));

//--- bench/test_pomc_ctrl.sv
// Self-checking bench for the operating mode controller
`timescale 1ns/1ps
`include "pomc_map.vh"
module test_pomc_ctrl;
	localparam [1:0] STP = `POMC_MODE_STOP;
	localparam [1:0] ST = `POMC_MODE_START;
	localparam [1:0] RN = `POMC_MODE_RUN;
	localparam [1:0] HD = `POMC_MODE_HOLD;
	logic ref_clk = 0, rst = 1, run_req = 0, stop_req = 0, cold_start_present = 0, overall_reset_req = 0;
	logic step_req = 0, resume_req = 0, kick_en = 1, project_reload = 0;
	logic [2:0] bp_active = 0;
	logic [47:0] bp_addr = 0;
	logic [15:0] cycle_limit_ms = 16'h0064, lat = 16'h0006;
	logic [3:0] subst_en = 4'h2;
	logic [7:0] ao_kind = 8'h06;
	logic [63:0] ao_prog = 64'h1111_2222_3333_4444, ao_subst = 64'h5555_6666_7777_8888;
	wire phase_done, wdog_kick, exec_en, timers_run, step_allowed, output_lock_q, user_mem_clear_q;
	wire wdog_err_q, cycle_err_q, led_green_q, led_yellow_q, led_red_q;
	wire [15:0] exec_addr;
	wire [63:0] ao_out;
	wire [1:0] mode_q;
	wire [2:0] phase_q;
	int err_count = 0, compares = 0, t;
	always #2.5 ref_clk = ~ref_clk;
	pomc_ctrl #(.WDOG_CYC(50), .START_CYC(40), .HALF_HZ_CYC(8), .MS_CYC(10)) uut (.ref_clk(ref_clk), .rst(rst),
		.run_req(run_req), .stop_req(stop_req), .cold_start_present(cold_start_present),
		.overall_reset_req(overall_reset_req), .project_reload(project_reload), .bp_active(bp_active),
		.bp_addr(bp_addr),
		.step_req(step_req), .resume_req(resume_req), .exec_addr(exec_addr), .phase_done(phase_done),
		.wdog_kick(wdog_kick), .cycle_limit_ms(cycle_limit_ms), .subst_en(subst_en), .ao_kind(ao_kind),
		.ao_prog(ao_prog), .ao_subst(ao_subst), .ao_out(ao_out), .mode_q(mode_q), .phase_q(phase_q),
		.exec_en(exec_en), .timers_run(timers_run), .step_allowed(step_allowed), .output_lock_q(output_lock_q),
		.user_mem_clear_q(user_mem_clear_q), .wdog_err_q(wdog_err_q), .cycle_err_q(cycle_err_q),
		.led_green_q(led_green_q), .led_yellow_q(led_yellow_q), .led_red_q(led_red_q));
	pomc_engine_model u_eng (.ref_clk(ref_clk), .rst(rst), .mode_q(mode_q), .phase_q(phase_q), .kick_en(kick_en),
		.lat(lat), .phase_done(phase_done), .wdog_kick(wdog_kick), .exec_addr(exec_addr));
	task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
		compares++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED at %0t: %s got %h", $time, m, g);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk);
	endtask
	// Bounded wait so a stuck mode reports instead of hanging
	task automatic wait_mode(input logic [1:0] m);
		for (int i = 0; i < 400 && mode_q !== m; i++) cyc(1);
		chk(mode_q, m, "mode");
	endtask
	task automatic toggles(input int n);
		logic p;
		t = 0;
		p = led_green_q;
		repeat (n) begin
			cyc(1);
			if (led_green_q !== p) t++;
			p = led_green_q;
		end
	endtask
	task automatic step_cnt;
		step_req = 1;
		cyc(1);
		step_req = 0;
		t = 0;
		repeat (3) begin
			if (exec_en === 1'b1) t++;
			cyc(1);
		end
	endtask
	task t_start;
		run_req = 1;
		wait_mode(ST);
		run_req = 0;
		chk(phase_q, `POMC_PH_CLR_IN, "clr_in");
		toggles(16);
		chk(t > 0, 1, "start blink");
		wait_mode(RN);
		cyc(2);
		chk(ao_out, ao_prog, "ao run");
		cyc(40);
		toggles(20);
		chk({t[3:0], led_green_q, timers_run}, 6'h03, "green run");
		for (int k = 0; k < 40 && phase_q !== `POMC_PH_READ_IN; k++) cyc(1);
		chk(phase_q, `POMC_PH_READ_IN, "cycle start");
		for (int i = 5; i < 8; i++) begin
			for (int k = 0; k < 30 && phase_q === i - 1; k++) cyc(1);
			chk(phase_q, i == 7 ? 3'h4 : i, "cycle order");
		end
	endtask
	task t_bp;
		bp_addr = 48'h0003_0000_0000;
		bp_active = 3'b100;
		wait_mode(HD);
		chk({led_red_q, output_lock_q, timers_run}, 3'b110, "hold");
		toggles(32);
		chk(t, 4, "hold blink");
		step_cnt;
		chk(t, 1, "step");
		bp_active = 3'b111;
		cyc(1);
		step_cnt;
		chk({t[1:0], step_allowed, mode_q}, {3'b000, HD}, "no step");
		bp_active = 0;
		resume_req = 1;
		cyc(1);
		resume_req = 0;
		wait_mode(RN);
	endtask
	task wdog_trip;
		kick_en = 0;
		run_req = 1;
		wait_mode(ST);
		wait_mode(STP);
		chk(wdog_err_q, 1, "wdog");
		cyc(10);
		chk({mode_q, exec_en}, {STP, 1'b0}, "refused");
		kick_en = 1;
	endtask
	task t_wdog;
		stop_req = 1;
		wait_mode(STP);
		stop_req = 0;
		wdog_trip;
		cold_start_present = 1;
		wait_mode(RN);
		run_req = 0;
		cold_start_present = 0;
		stop_req = 1;
		wait_mode(STP);
		stop_req = 0;
		wdog_trip;
		project_reload = 1;
		wait_mode(ST);
		project_reload = 0;
		run_req = 0;
		stop_req = 1;
		wait_mode(STP);
		stop_req = 0;
		wdog_trip;
		run_req = 0;
		overall_reset_req = 1;
		cyc(1);
		overall_reset_req = 0;
		chk({user_mem_clear_q, wdog_err_q}, 2'b10, "mem clear");
	endtask
	task t_cycle;
		cycle_limit_ms = 1;
		lat = 16'h000c;
		run_req = 1;
		wait_mode(ST);
		run_req = 0;
		wait_mode(RN);
		wait_mode(STP);
		chk({cycle_err_q, output_lock_q}, 2'b11, "cycle limit");
		cyc(2);
		chk(ao_out, {32'h0, ao_subst[31:16], `POMC_AO_4MA}, "ao locked");
	endtask
	task report_and_stop;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		#50000;
		err_count++;
		report_and_stop;
	end
	initial begin
		cyc(10);
		chk({mode_q, output_lock_q}, {STP, 1'b1}, "reset");
		chk(ao_out, 64'h0, "reset ao");
		cyc(10);
		rst = 0;
		cyc(2);
		chk(led_yellow_q, 1, "yellow");
		t_start;
		t_bp;
		t_wdog;
		t_cycle;
		report_and_stop;
	end
endmodule
